// ---- bench/pol_group_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pol_group_model (
  input  wire logic       pclk,         // System clock
  input  wire logic       presetn,      // Reset, active low
  input  wire logic [3:0] oe_n,         // Block pulls line while low
  input  wire logic [3:0] drv,          // Level the block drives
  input  wire logic [3:0] fault_pull,   // Converter pulls its own line
  input  wire logic [3:0] program_req,  // Programming wanted
  output var  logic [3:0] line,         // Resolved line level
  output var  logic [3:0] program_done  // Programming finished pulse
);
  logic [4:0] cnt [4];
  // Pulled-up line: released reads high
  always_comb
  begin
    for (int g = 0; g < 4; g++)
      line[g] = (oe_n[g] ? 1'b1 : drv[g]) & ~fault_pull[g];
  end
  // Group g needs 4 + 5g cycles, so answers are both prompt and slow
  always_ff @(posedge pclk or negedge presetn)
  begin
    for (int g = 0; g < 4; g++)
    begin
      program_done[g] <= 1'b0;
      if (!presetn || !program_req[g])
        cnt[g] <= 5'h00;
      else if (cnt[g] == 5'(3 + 5 * g))
      begin
        cnt[g] <= 5'h00;
        program_done[g] <= 1'b1;
      end
      else
        cnt[g] <= cnt[g] + 5'h01;
    end
  end
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int CB_CYC = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  ok_in, ok_out, ok_oe_n, int_n, done, req, m_up, m_dn, fault;
  logic        mains_n, sdn_n, err_n, save, fe, cb;
  int          n_fail, checked, n_save, cb_len;

  group_fault_inhibit_manager #(.CROWBAR_CYCLES(CB_CYC)) group_fault_inhibit_manager_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ok_line_in(ok_in), .ok_line_out(ok_out), .ok_line_oe_n(ok_oe_n), .interrupt_input_n(int_n),
    .mains_loss_input_n(mains_n), .system_shutdown_input_n(sdn_n), .error_report_n(err_n),
    .program_done(done), .program_req(req), .runtime_save(save), .margin_up(m_up),
    .margin_down(m_dn), .front_end_enable_out(fe), .crowbar_trigger_out(cb));

  pol_group_model pol_group_model_i (
    .pclk(pclk), .presetn(presetn), .oe_n(ok_oe_n), .drv(ok_out), .fault_pull(fault),
    .program_req(req), .line(ok_in), .program_done(done));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    if (save === 1'b1)
      n_save++;
    if (cb === 1'b1)
      cb_len++;
  end

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 50)
    begin
      chk("pready", 32'h0, 32'h1);
      wrap_up();
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task rd(input logic [7:0] a, input string what, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, r & m, exp);
  endtask

  // Polls line enables (sel 0) or programming requests (sel 1)
  task wait_on(input int sel, input logic [3:0] exp, input int bound, input string what);
    int         i;
    logic [3:0] v;
    i = 0;
    v = sel ? req : ok_oe_n;
    while (v !== exp && i < bound)
    begin
      @(posedge pclk);
      #1;
      v = sel ? req : ok_oe_n;
      i++;
    end
    chk(what, {28'h0, v}, {28'h0, exp});
    if (v !== exp)
      wrap_up();
  endtask

  task t_reset;
    logic [31:0] r;
    logic        e;
    wait_on(0, 4'hf, 200, "groups up");
    chk("line drive", {28'h0, ok_out}, 32'h0);
    rd(gfim_pkg::CTRL_OFS, "ctrl", 32'h1f, 32'h15);
    rd(gfim_pkg::PMAP_OFS, "pmap", 32'hffff_ffff, 32'h0);
    rd(gfim_pkg::ICFG_OFS, "icfg", 32'hffff_ffff, 32'h0);
    rd(gfim_pkg::MARG_OFS, "marg", 32'hffff_ffff, 32'h0);
    rd(gfim_pkg::STAT_OFS, "stat", 32'h0000_f0f0, 32'h0000_f0f0);
    apb(1'b0, 8'h18, 32'h0, r, e);
    chk("unmapped", {31'h0, e}, 32'h1);
    $display("test reset done");
  endtask

  task t_margin;
    wr(gfim_pkg::MARG_OFS, 32'he1);
    repeat (2) @(posedge pclk);
    #1;
    chk("margin up", {28'h0, m_up}, 32'h1);
    chk("margin down", {28'h0, m_dn}, 32'h4);
    $display("test margin done");
  endtask

  task t_group;
    wr(gfim_pkg::GCMD_OFS, 32'h22);
    wait_on(0, 4'hd, 50, "group off");
    rd(gfim_pkg::GCMD_OFS, "gcmd", 32'hffff_ffff, 32'h0);
    wr(gfim_pkg::GCMD_OFS, 32'h02);
    wait_on(0, 4'hf, 50, "group on");
    $display("test group done");
  endtask

  task t_inhibit;
    wr(gfim_pkg::ICFG_OFS, 32'h06);
    @(posedge pclk);
    int_n[0] <= 1'b0;
    wait_on(0, 4'h9, gfim_pkg::PROP_MAX_CYC, "inhibit");
    @(posedge pclk);
    int_n[0] <= 1'b1;
    wait_on(0, 4'hf, 50, "inhibit off");
    $display("test inhibit done");
  endtask

  task t_trigger;
    wr(gfim_pkg::ICFG_OFS, 32'h8000_0000);
    @(posedge pclk);
    int_n[3] <= 1'b0;
    wait_on(1, 4'h8, 50, "trigger req");
    wait_on(1, 4'h0, 100, "trigger prog");
    rd(gfim_pkg::STAT_OFS, "prog bit", 32'h0000_8080, 32'h0000_8080);
    @(posedge pclk);
    int_n[3] <= 1'b1;
    wait_on(0, 4'h7, 50, "trigger off");
    rd(gfim_pkg::STAT_OFS, "prog clear", 32'h0000_f000, 32'h0);
    wr(gfim_pkg::ICFG_OFS, 32'h0);
    $display("test trigger done");
  endtask

  task t_error;
    wr(gfim_pkg::PMAP_OFS, 32'h4);
    wr(gfim_pkg::CTRL_OFS, 32'h1f);
    cb_len = 0;
    @(posedge pclk);
    fault <= 4'h1;
    err_n <= 1'b0;
    wait_on(0, 4'h3, gfim_pkg::PROP_MAX_CYC, "propagate");
    repeat (CB_CYC + 10) @(posedge pclk);
    #1;
    chk("front end", {31'h0, fe}, 32'h0);
    chk("crowbar len", 32'(cb_len), 32'(CB_CYC));
    @(posedge pclk);
    fault <= 4'h0;
    err_n <= 1'b1;
    wait_on(0, 4'h7, 50, "propagate off");
    wr(gfim_pkg::CTRL_OFS, 32'h15);
    repeat (2) @(posedge pclk);
    #1;
    chk("front end on", {31'h0, fe}, 32'h1);
    $display("test error done");
  endtask

  task t_mains(input int k);
    int s0;
    wr(gfim_pkg::CTRL_OFS, k ? 32'h11 : 32'h15);
    s0 = n_save;
    @(posedge pclk);
    if (k)
      sdn_n <= 1'b0;
    else
      mains_n <= 1'b0;
    wait_on(0, 4'h0, gfim_pkg::SHUT_MAX_CYC, "all off");
    repeat (3) @(posedge pclk);
    chk("run time save", 32'(n_save - s0), 32'h1);
    rd(gfim_pkg::STAT_OFS, "event", 32'h0003_f000, 32'h1 << (16 + k));
    @(posedge pclk);
    sdn_n <= 1'b1;
    mains_n <= 1'b1;
    wait_on(1, 4'hf, 50, "reprogram");
    wait_on(1, 4'h0, 100, "reprog done");
    if (k == 0)
      wait_on(0, 4'hf, 50, "auto on");
    else
    begin
      repeat (10) @(posedge pclk);
      #1;
      chk("stay off", {28'h0, ok_oe_n}, 32'h0);
      wr(gfim_pkg::GCMD_OFS, 32'h0f);
      wait_on(0, 4'hf, 50, "host on");
    end
    wr(gfim_pkg::STAT_OFS, 32'h1 << (16 + k));
    rd(gfim_pkg::STAT_OFS, "flag clear", 32'h1 << (16 + k), 32'h0);
    $display("test shutdown %0d done", k);
  endtask

  initial
  begin
    n_fail = 0;
    checked = 0;
    n_save = 0;
    cb_len = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    int_n = 4'hf;
    mains_n = 1'b1;
    sdn_n = 1'b1;
    err_n = 1'b1;
    fault = 4'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_margin();
    t_group();
    t_inhibit();
    t_trigger();
    t_error();
    t_mains(0);
    t_mains(1);
    wrap_up();
  end
endmodule
`default_nettype wire

// ---- rtl/crowbar_pulse_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module crowbar_pulse_timer #(
  parameter int CYCLES = gfim_pkg::CROWBAR_CYC
) (
  input  wire logic clk,   // System clock
  input  wire logic rst_n, // Async reset, active low
  pulse_if.tmr      tif    // Start request and pulse level
);
  localparam int CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          active;
  } timer_state_t;

  timer_state_t r;
  timer_state_t next_r;
  int unsigned  len;

  if (CYCLES < 2)
  begin : g_chk
    $error("crowbar pulse needs at least two cycles");
  end

  always_comb
  begin
    next_r = r;
    if (r.active)
    begin
      if (r.cnt == '0)
        next_r.active = 1'b0;
      else
        next_r.cnt = r.cnt - 1'b1;
    end
    else if (tif.start)
    begin
      next_r.active = 1'b1;
      next_r.cnt    = CW'(CYCLES - 1);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= next_r;
  end

  assign tif.active = r.active;

  // Length of the running pulse, for checking only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      len <= 0;
    else if (r.active)
      len <= len + 1;
    else
      len <= 0;
  end

  property p_cb_width;
    @(posedge clk) disable iff (!rst_n)
    $fell(r.active) |-> (len == CYCLES);
  endproperty
  a_cb_width: assert property (p_cb_width) else $error("crowbar pulse length wrong");
endmodule
`default_nettype wire

// ---- rtl/gfim_pkg.sv ----
// What this block does
// - Externally pulled-low group line pulls the mapped other group lines low when enabled.
// - A propagated error may drop the front-end enable and fire the crowbar.
// - Propagation to groups, front end and crowbar completes well under 10 us.
// - A margin command moves every converter of a group the same direction.
// - Host commands turn single groups on and off at run time.
// - Each interrupt is either an inhibit or a reprogramming trigger, never both.
// - A low inhibit interrupt holds low every group line in its mask.
// - Inhibit reaches the selected lines within about 10 us.
// - Inhibit released lets the affected group lines go high again.
// - Converter programming continues while an inhibit is held low.
// - Trigger interrupt n requests and switches group n only, fixed mapping.
// - Trigger falling programs its group, then turns it on if auto turn-on.
// - Trigger rising forces its group line low and clears all programming status.
// - Mains loss or system shutdown low forces every group line low.
// - That event also clears programming status, saves run time, sets a status flag.
// - After release all groups are programmed, then on only if auto turn-on.
// - Shutdown reaches all lines within about 1 ms.
// - Front-end enable output follows host control, high enables.
// - A triggered, enabled crowbar gives one 1 ms high pulse.
`default_nettype none
package gfim_pkg;
  localparam int NGRP = 4;
  localparam int NINT = 4;
  localparam int NSYNC = 11;

  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PMAP_OFS = 8'h04;
  localparam logic [7:0] ICFG_OFS = 8'h08;
  localparam logic [7:0] GCMD_OFS = 8'h0c;
  localparam logic [7:0] MARG_OFS = 8'h10;
  localparam logic [7:0] STAT_OFS = 8'h14;

  localparam int CTRL_FE    = 0;
  localparam int CTRL_CB    = 1;
  localparam int CTRL_AUTO  = 2;
  localparam int CTRL_ERRFE = 3;
  localparam int CTRL_PROP  = 4;
  localparam int CTRL_W     = 5;
  localparam logic [4:0] CTRL_RST = 5'h15;
  localparam logic [15:0] PMAP_RST = 16'h0000;
  localparam logic [31:0] ICFG_RST = 32'h0000_0000;
  localparam logic [7:0] MARG_RST = 8'h00;

  localparam int ICFG_FLD  = 8;
  localparam int ICFG_MODE = 7;
  localparam int GCMD_ON   = 0;
  localparam int GCMD_OFF  = 4;

  localparam int STAT_LINE  = 0;
  localparam int STAT_ON    = 4;
  localparam int STAT_PEND  = 8;
  localparam int STAT_PROG  = 12;
  localparam int STAT_MAINS = 16;
  localparam int STAT_SDN   = 17;

  localparam int CLK_PERIOD_NS = 10;
  localparam int CROWBAR_NS    = 1000000;
  localparam int CROWBAR_CYC   = CROWBAR_NS / CLK_PERIOD_NS;
  localparam int PROP_MAX_NS   = 10000;
  localparam int PROP_MAX_CYC  = PROP_MAX_NS / CLK_PERIOD_NS;
  localparam int SHUT_MAX_NS   = 1000000;
  localparam int SHUT_MAX_CYC  = SHUT_MAX_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ---- rtl/group_fault_inhibit_manager.sv ----
`timescale 1ns/1ps
`default_nettype none
module group_fault_inhibit_manager #(
  parameter int CROWBAR_CYCLES = gfim_pkg::CROWBAR_CYC
) (
  input  wire logic        pclk,                   // APB clock, 100 MHz
  input  wire logic        presetn,                // Async reset, active low
  input  wire logic        psel,                   // APB select
  input  wire logic        penable,                // APB access phase
  input  wire logic        pwrite,                 // APB direction
  input  wire logic [7:0]  paddr,                  // APB byte address
  input  wire logic [31:0] pwdata,                 // APB write data
  output var  logic [31:0] prdata,                 // APB read data
  output var  logic        pready,                 // APB ready
  output var  logic        pslverr,                // APB error, unmapped
  input  wire logic [3:0]  ok_line_in,             // Sensed group lines
  output var  logic [3:0]  ok_line_out,            // Driven level, always low
  output var  logic [3:0]  ok_line_oe_n,           // Low while pulling low
  input  wire logic [3:0]  interrupt_input_n,      // Interrupts, first at bit 0
  input  wire logic        mains_loss_input_n,     // Mains loss, active low
  input  wire logic        system_shutdown_input_n,// Shutdown, active low
  input  wire logic        error_report_n,         // Fault is an error, low
  input  wire logic [3:0]  program_done,           // Group programmed pulse
  output var  logic [3:0]  program_req,            // Group programming wanted
  output var  logic        runtime_save,           // Store run time, pulse
  output var  logic [3:0]  margin_up,              // Group margined up
  output var  logic [3:0]  margin_down,            // Group margined down
  output var  logic        front_end_enable_out,   // Front end enable
  output var  logic        crowbar_trigger_out     // Crowbar pulse
);
  localparam int NG = gfim_pkg::NGRP;
  localparam int NI = gfim_pkg::NINT;

  typedef struct packed {
    logic [gfim_pkg::CTRL_W-1:0] ctrl;
    logic [15:0] prop_map;
    logic [31:0] int_cfg;
    logic [7:0]  margin;
    logic [3:0]  group_on;
    logic [3:0]  prog_pend;
    logic [3:0]  prog_stat;
    logic [1:0]  sticky;
    logic [3:0]  int_prev;
    logic        shut_prev;
    logic        err_prev;
    logic [3:0]  oe_n;
    logic [3:0]  od1;
    logic [3:0]  od2;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        save;
    logic        cb_start;
    logic [3:0]  mup;
    logic [3:0]  mdn;
    logic [3:0]  ok_out;
  } mgr_state_t;

  mgr_state_t r;
  mgr_state_t next_r;

  logic [gfim_pkg::NSYNC-1:0] sync_q;
  logic [3:0] s_ok;
  logic [3:0] s_int;
  logic       s_mains;
  logic       s_sdn;
  logic       s_err;
  logic       shut_ok;
  logic [3:0] ext_low;
  logic       err_ev;
  logic [3:0] prop_pull;
  logic [3:0] inh_pull;
  logic [3:0] trig_fall;
  logic [3:0] trig_rise;
  logic       apb_acc;
  logic [2:0] acc_idx;

  pulse_if cb_if ();

  if (CROWBAR_CYCLES < 2)
  begin : g_chk
    $error("crowbar cycle count too small");
  end

  // Register index from byte address; 0 means unmapped
  function automatic logic [2:0] reg_index(input logic [7:0] a);
    if (a == gfim_pkg::CTRL_OFS)
      return 3'h1;
    else if (a == gfim_pkg::PMAP_OFS)
      return 3'h2;
    else if (a == gfim_pkg::ICFG_OFS)
      return 3'h3;
    else if (a == gfim_pkg::GCMD_OFS)
      return 3'h4;
    else if (a == gfim_pkg::MARG_OFS)
      return 3'h5;
    else if (a == gfim_pkg::STAT_OFS)
      return 3'h6;
    else
      return 3'h0;
  endfunction

  input_sync #(
    .W   (gfim_pkg::NSYNC),
    .RST ({gfim_pkg::NSYNC{1'b1}})
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({error_report_n, system_shutdown_input_n, mains_loss_input_n,
             interrupt_input_n, ok_line_in}),
    .q     (sync_q)
  );

  assign s_ok    = sync_q[3:0];
  assign s_int   = sync_q[7:4];
  assign s_mains = sync_q[8];
  assign s_sdn   = sync_q[9];
  assign s_err   = sync_q[10];

  crowbar_pulse_timer #(
    .CYCLES (CROWBAR_CYCLES)
  ) u_cb (
    .clk   (pclk),
    .rst_n (presetn),
    .tif   (cb_if.tmr)
  );

  assign cb_if.start = r.cb_start;

  always_comb
  begin
    shut_ok = s_mains & s_sdn;
    // Low level seen while we have not pulled for three cycles
    ext_low = ~s_ok & r.oe_n & r.od1 & r.od2;
    err_ev  = r.ctrl[gfim_pkg::CTRL_PROP] & r.ctrl[gfim_pkg::CTRL_ERRFE]
              & (|ext_low) & ~s_err;
    apb_acc = psel & penable & r.pready;
    acc_idx = reg_index(paddr);
    prop_pull = '0;
    inh_pull  = '0;
    for (int g = 0; g < NG; g++)
    begin
      if (r.ctrl[gfim_pkg::CTRL_PROP] && ext_low[g])
        prop_pull = prop_pull | (r.prop_map[g*4 +: 4] & ~(4'h1 << g));
    end
    for (int i = 0; i < NI; i++)
    begin
      // Mode bit selects one function only
      if (!r.int_cfg[i*gfim_pkg::ICFG_FLD + gfim_pkg::ICFG_MODE] && !s_int[i])
        inh_pull = inh_pull | r.int_cfg[i*gfim_pkg::ICFG_FLD +: 4];
      trig_fall[i] = r.int_cfg[i*gfim_pkg::ICFG_FLD + gfim_pkg::ICFG_MODE]
                     & r.int_prev[i] & ~s_int[i];
      trig_rise[i] = r.int_cfg[i*gfim_pkg::ICFG_FLD + gfim_pkg::ICFG_MODE]
                     & ~r.int_prev[i] & s_int[i];
    end
  end

  always_comb
  begin
    next_r = r;
    next_r.save     = 1'b0;
    next_r.cb_start = 1'b0;
    next_r.pslverr  = 1'b0;
    next_r.prdata   = '0;
    next_r.pready   = psel & penable & ~r.pready;
    next_r.int_prev = s_int;
    next_r.shut_prev = shut_ok;
    next_r.err_prev = err_ev;
    next_r.od1 = r.oe_n;
    next_r.od2 = r.od1;
    next_r.ok_out = '0;

    // Read data and error are registered at the same edge as pready
    if (next_r.pready)
    begin
      next_r.pslverr = (acc_idx == 3'h0);
      if (!pwrite)
      begin
        if (acc_idx == 3'h1)
          next_r.prdata = {27'h0, r.ctrl};
        else if (acc_idx == 3'h2)
          next_r.prdata = {16'h0, r.prop_map};
        else if (acc_idx == 3'h3)
          next_r.prdata = r.int_cfg;
        else if (acc_idx == 3'h5)
          next_r.prdata = {24'h0, r.margin};
        else if (acc_idx == 3'h6)
          next_r.prdata = {14'h0, r.sticky, r.prog_stat, r.prog_pend,
                           r.group_on, s_ok};
      end
    end

    // Host writes, taken at the completing edge
    if (apb_acc && pwrite)
    begin
      if (acc_idx == 3'h1)
        next_r.ctrl = pwdata[gfim_pkg::CTRL_W-1:0];
      else if (acc_idx == 3'h2)
        next_r.prop_map = pwdata[15:0];
      else if (acc_idx == 3'h3)
        next_r.int_cfg = pwdata;
      else if (acc_idx == 3'h4)
        next_r.group_on = (r.group_on | pwdata[gfim_pkg::GCMD_ON +: 4])
                          & ~pwdata[gfim_pkg::GCMD_OFF +: 4];
      else if (acc_idx == 3'h5)
        next_r.margin = pwdata[7:0];
      else if (acc_idx == 3'h6)
        next_r.sticky = r.sticky & ~pwdata[gfim_pkg::STAT_SDN:gfim_pkg::STAT_MAINS];
    end

    // Programming completion, independent of any inhibit
    for (int g = 0; g < NG; g++)
    begin
      if (r.prog_pend[g] && program_done[g])
      begin
        next_r.prog_pend[g] = 1'b0;
        next_r.prog_stat[g] = 1'b1;
        if (r.ctrl[gfim_pkg::CTRL_AUTO])
          next_r.group_on[g] = 1'b1;
      end
    end

    // Fixed trigger mapping: interrupt n on group n
    for (int i = 0; i < NI; i++)
    begin
      if (trig_fall[i])
        next_r.prog_pend[i] = 1'b1;
      if (trig_rise[i])
      begin
        next_r.prog_pend[i] = 1'b0;
        next_r.group_on[i]  = 1'b0;
        next_r.prog_stat    = '0;
      end
    end

    // Error: drop the front end, fire the crowbar once per event
    if (err_ev && !r.err_prev)
    begin
      next_r.ctrl[gfim_pkg::CTRL_FE] = 1'b0;
      next_r.cb_start = r.ctrl[gfim_pkg::CTRL_CB];
    end

    // Mains loss or shutdown entry and release
    if (!shut_ok)
    begin
      next_r.group_on  = '0;
      next_r.prog_pend = '0;
      if (r.shut_prev)
      begin
        next_r.prog_stat = '0;
        next_r.save      = 1'b1;
      end
    end
    else if (!r.shut_prev)
      next_r.prog_pend = '1;
    // Sticky flags: hardware set wins over software clear
    if (!s_mains)
      next_r.sticky[0] = 1'b1;
    if (!s_sdn)
      next_r.sticky[1] = 1'b1;

    // Margin direction per group, both bits means nominal
    for (int g = 0; g < NG; g++)
    begin
      next_r.mup[g] = next_r.margin[2*g] & ~next_r.margin[2*g+1];
      next_r.mdn[g] = next_r.margin[2*g+1] & ~next_r.margin[2*g];
    end

    // Line drive: low enable only, released when nothing pulls
    next_r.oe_n = ~(~next_r.group_on | prop_pull | inh_pull
                    | {NG{~shut_ok}});
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r           <= '0;
      r.ctrl      <= gfim_pkg::CTRL_RST;
      r.prop_map  <= gfim_pkg::PMAP_RST;
      r.int_cfg   <= gfim_pkg::ICFG_RST;
      r.margin    <= gfim_pkg::MARG_RST;
      r.prog_pend <= '1;
      r.int_prev  <= '1;
      r.shut_prev <= 1'b1;
      r.oe_n      <= '0;
      r.od1       <= '0;
      r.od2       <= '0;
    end
    else
      r <= next_r;
  end

  assign prdata               = r.prdata;
  assign pready               = r.pready;
  assign pslverr              = r.pslverr;
  assign ok_line_out          = r.ok_out;
  assign ok_line_oe_n         = r.oe_n;
  assign program_req          = r.prog_pend;
  assign runtime_save         = r.save;
  assign margin_up            = r.mup;
  assign margin_down          = r.mdn;
  assign front_end_enable_out = r.ctrl[gfim_pkg::CTRL_FE];
  assign crowbar_trigger_out  = cb_if.active;

  sequence s_shut_entry;
    r.shut_prev && !shut_ok;
  endsequence

  sequence s_shut_effect;
    ##1 (runtime_save && r.prog_stat == 4'h0 && ok_line_oe_n == 4'h0);
  endsequence

  property p_prop;
    @(posedge pclk) disable iff (!presetn)
    (r.ctrl[gfim_pkg::CTRL_PROP] && ext_low[0] && r.prop_map[2]) |=> !ok_line_oe_n[2];
  endproperty
  a_prop: assert property (p_prop) else $error("fault not propagated");

  property p_err_fe;
    @(posedge pclk) disable iff (!presetn)
    (err_ev && !r.err_prev) |=> !front_end_enable_out;
  endproperty
  a_err_fe: assert property (p_err_fe) else $error("front end not dropped");

  property p_err_cb;
    @(posedge pclk) disable iff (!presetn)
    (err_ev && !r.err_prev && r.ctrl[gfim_pkg::CTRL_CB] && !crowbar_trigger_out)
      |-> ##2 crowbar_trigger_out;
  endproperty
  a_err_cb: assert property (p_err_cb) else $error("crowbar not fired");

  property p_inhibit;
    @(posedge pclk) disable iff (!presetn)
    (!s_int[0] && !r.int_cfg[gfim_pkg::ICFG_MODE] && r.int_cfg[2]) |=> !ok_line_oe_n[2];
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit did not pull line");

  property p_trig_rise;
    @(posedge pclk) disable iff (!presetn)
    (trig_rise[3] && r.shut_prev) |=> (!ok_line_oe_n[3] && r.prog_stat == 4'h0 && !program_req[3]);
  endproperty
  a_trig_rise: assert property (p_trig_rise) else $error("trigger release mishandled");

  property p_trig_fall;
    @(posedge pclk) disable iff (!presetn)
    (trig_fall[3] && shut_ok) |=> program_req[3];
  endproperty
  a_trig_fall: assert property (p_trig_fall) else $error("trigger did not request programming");

  property p_auto_on;
    @(posedge pclk) disable iff (!presetn)
    (program_req[0] && program_done[0] && shut_ok && !trig_rise[0] && !(apb_acc && pwrite))
      |=> (r.group_on[0] == ($past(r.ctrl[gfim_pkg::CTRL_AUTO]) | $past(r.group_on[0])));
  endproperty
  a_auto_on: assert property (p_auto_on) else $error("auto turn-on wrong");

  property p_shut;
    @(posedge pclk) disable iff (!presetn)
    s_shut_entry |-> s_shut_effect;
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown entry incomplete");

  property p_apb;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready;
  endproperty
  a_apb: assert property (p_apb) else $error("apb answer late");

  property p_release;
    @(posedge pclk) disable iff (!presetn)
    (!r.shut_prev && shut_ok) |=> (program_req == 4'hf);
  endproperty
  a_release: assert property (p_release) else $error("no reprogram after release");
endmodule
`default_nettype wire

// ---- rtl/input_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '1
) (
  input  wire logic         clk,   // System clock
  input  wire logic         rst_n, // Async reset, active low
  input  wire logic [W-1:0] d,     // Asynchronous inputs
  output var  logic [W-1:0] q      // Synchronised copy
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t r;
  sync_state_t next_r;

  if (W < 1)
  begin : g_chk
    $error("input_sync width must be at least one");
  end

  always_comb
  begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= {RST, RST};
    else
      r <= next_r;
  end

  assign q = r.s2;
endmodule
`default_nettype wire

// ---- rtl/pulse_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface pulse_if;
  logic start;
  logic active;
  modport ctl (output start, input active);
  modport tmr (input start, output active);
endinterface
`default_nettype wire
